// File: src/ctt_pkg.sv
// ==========================================================================
// Shared constants of the core tick timer
// ==========================================================================
package ctt_pkg;

    localparam int unsigned CNT_W  = 24;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;

    // ======================================================================
    // Register offsets from the timer base
    // ======================================================================
    localparam logic [ADDR_W-1:0] OFF_CONTROL_STATUS = 12'h010;
    localparam logic [ADDR_W-1:0] OFF_RELOAD_VALUE   = 12'h014;
    localparam logic [ADDR_W-1:0] OFF_CURRENT_COUNT  = 12'h018;
    localparam logic [ADDR_W-1:0] OFF_CALIBRATION    = 12'h01C;

    // ======================================================================
    // Control/status field positions
    // ======================================================================
    localparam int unsigned CSR_ENABLE_BIT   = 0;
    localparam int unsigned CSR_IRQ_EN_BIT   = 1;
    localparam int unsigned CSR_CLK_SEL_BIT  = 2;
    localparam int unsigned CSR_ZERO_FLG_BIT = 16;

    // ======================================================================
    // Reset values
    // ======================================================================
    localparam logic             ENABLE_RST  = 1'b0;
    localparam logic             IRQ_EN_RST  = 1'b0;
    localparam logic             CLK_SEL_RST = 1'b0;
    localparam logic             FLAG_RST    = 1'b0;
    localparam logic [CNT_W-1:0] RELOAD_RST  = 24'h000000;
    localparam logic [CNT_W-1:0] COUNT_RST   = 24'h000000;
    localparam logic [CNT_W-1:0] CALIB_RST   = 24'h000004;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] off);
        return addr == off;
    endfunction

endpackage

// File: src/ctt_cnt_if.sv
`timescale 1ns/1ps
// ==========================================================================
// Link between the register side, the rate divider and the counter
// ==========================================================================
interface ctt_cnt_if;
    logic                      run;
    logic                      full_rate;
    logic                      clear;
    logic                      tick;
    logic [ctt_pkg::CNT_W-1:0] reload;
    logic [ctt_pkg::CNT_W-1:0] count;
    logic                      zero_evt;

    modport ctrl (output run, output full_rate, output clear, output reload,
                  input tick, input count, input zero_evt);
    modport div  (input run, input full_rate, output tick);
    modport cnt  (input run, input clear, input tick, input reload,
                  output count, output zero_evt);
endinterface

// File: src/ctt_rate_div.sv
`timescale 1ns/1ps
// ==========================================================================
// Count-clock divider: full rate or every second core clock
// ==========================================================================
module ctt_rate_div (
    input  wire logic core_clk,
    input  wire logic rst,
    ctt_cnt_if.div    cif
);
    typedef struct packed {
        logic phase;
    } ctt_div_s;

    ctt_div_s st_reg;
    ctt_div_s st_next;

    // The phase is held at zero while stopped so that a restart always
    // waits one core clock before the first half-rate tick.
    always_comb begin
        st_next       = st_reg;
        st_next.phase = cif.run ? ~st_reg.phase : 1'b0;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cif.tick = cif.run & (cif.full_rate | st_reg.phase);
endmodule

// File: src/ctt_down_counter.sv
`timescale 1ns/1ps
// ==========================================================================
// 24-bit down counter with reload at zero
// ==========================================================================
module ctt_down_counter (
    input  wire logic core_clk,
    input  wire logic rst,
    ctt_cnt_if.cnt    cif
);
    typedef struct packed {
        logic [ctt_pkg::CNT_W-1:0] count;
        logic                      zero_evt;
    } ctt_cnt_s;

    ctt_cnt_s st_reg;
    ctt_cnt_s st_next;

    always_comb begin
        st_next          = st_reg;
        st_next.zero_evt = 1'b0;
        if (cif.clear) begin
            st_next.count = '0;
        end else if (cif.run && cif.tick) begin
            if (st_reg.count == '0) begin
                st_next.count = cif.reload;
            end else begin
                st_next.count    = st_reg.count - 24'h000001;
                st_next.zero_evt = (st_reg.count == 24'h000001);
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg.count    <= ctt_pkg::COUNT_RST;
            st_reg.zero_evt <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cif.count    = st_reg.count;
    assign cif.zero_evt = st_reg.zero_evt;
endmodule

// File: src/ctt_core_tick_timer.sv
`timescale 1ns/1ps
module ctt_core_tick_timer (
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    input  wire logic [ctt_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    input  wire logic [ctt_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic [ctt_pkg::CNT_W-1:0]   calibration_source_setting,
    output logic      [ctt_pkg::DATA_W-1:0]  reg_rdata,
    output logic                             reg_rvalid,
    output logic                             tick_irq
);
    // ======================================================================
    // State
    // ======================================================================
    typedef struct packed {
        logic                       enable;
        logic                       irq_enable;
        logic                       clk_sel;
        logic                       zero_flag;
        logic [ctt_pkg::CNT_W-1:0]  reload;
        logic [ctt_pkg::CNT_W-1:0]  calib;
        logic [ctt_pkg::DATA_W-1:0] rdata;
        logic                       rvalid;
        logic                       irq;
    } ctt_main_s;

    ctt_main_s st_reg;
    ctt_main_s st_next;

    ctt_cnt_if cif ();

    logic rd_csr;
    logic rd_rvr;
    logic rd_cvr;
    logic rd_cal;
    logic wr_csr;
    logic wr_rvr;
    logic wr_cvr;

    // ======================================================================
    // Counting path
    // ======================================================================
    ctt_rate_div u_rate_div (
        .core_clk (core_clk),
        .rst      (rst),
        .cif      (cif.div)
    );

    ctt_down_counter u_down_counter (
        .core_clk (core_clk),
        .rst      (rst),
        .cif      (cif.cnt)
    );

    assign cif.run       = st_reg.enable;
    assign cif.full_rate = st_reg.clk_sel;
    assign cif.reload    = st_reg.reload;
    assign cif.clear     = wr_cvr;

    // ======================================================================
    // Register decode
    // ======================================================================
    assign rd_csr = reg_rd && ctt_pkg::reg_hit(reg_addr, ctt_pkg::OFF_CONTROL_STATUS);
    assign rd_rvr = reg_rd && ctt_pkg::reg_hit(reg_addr, ctt_pkg::OFF_RELOAD_VALUE);
    assign rd_cvr = reg_rd && ctt_pkg::reg_hit(reg_addr, ctt_pkg::OFF_CURRENT_COUNT);
    assign rd_cal = reg_rd && ctt_pkg::reg_hit(reg_addr, ctt_pkg::OFF_CALIBRATION);
    assign wr_csr = reg_wr && ctt_pkg::reg_hit(reg_addr, ctt_pkg::OFF_CONTROL_STATUS);
    assign wr_rvr = reg_wr && ctt_pkg::reg_hit(reg_addr, ctt_pkg::OFF_RELOAD_VALUE);
    assign wr_cvr = reg_wr && ctt_pkg::reg_hit(reg_addr, ctt_pkg::OFF_CURRENT_COUNT);

    // ======================================================================
    // Next state
    // ======================================================================
    always_comb begin
        st_next        = st_reg;
        st_next.rvalid = reg_rd;
        st_next.rdata  = '0;
        // The interrupt is a one-cycle pulse on its own line, so it needs
        // no acknowledge from software.
        st_next.irq    = cif.zero_evt && st_reg.irq_enable;
        // The ten-ms field lives in the system configuration block; this
        // copy only follows it, so software writes here have no effect.
        st_next.calib  = calibration_source_setting;

        if (wr_csr) begin
            st_next.enable     = reg_wdata[ctt_pkg::CSR_ENABLE_BIT];
            st_next.irq_enable = reg_wdata[ctt_pkg::CSR_IRQ_EN_BIT];
            st_next.clk_sel    = reg_wdata[ctt_pkg::CSR_CLK_SEL_BIT];
        end
        if (wr_rvr) begin
            // Upper bits are dropped; software keeps them zero.
            st_next.reload = reg_wdata[ctt_pkg::CNT_W-1:0];
        end

        // A zero event in the same cycle as the clear still sets the flag.
        if (rd_csr || wr_cvr) begin
            st_next.zero_flag = 1'b0;
        end
        if (cif.zero_evt) begin
            st_next.zero_flag = 1'b1;
        end

        if (rd_csr) begin
            st_next.rdata[ctt_pkg::CSR_ENABLE_BIT]   = st_reg.enable;
            st_next.rdata[ctt_pkg::CSR_IRQ_EN_BIT]   = st_reg.irq_enable;
            st_next.rdata[ctt_pkg::CSR_CLK_SEL_BIT]  = st_reg.clk_sel;
            st_next.rdata[ctt_pkg::CSR_ZERO_FLG_BIT] = st_reg.zero_flag;
        end else if (rd_rvr) begin
            st_next.rdata[ctt_pkg::CNT_W-1:0] = st_reg.reload;
        end else if (rd_cvr) begin
            st_next.rdata[ctt_pkg::CNT_W-1:0] = cif.count;
        end else if (rd_cal) begin
            st_next.rdata[ctt_pkg::CNT_W-1:0] = st_reg.calib;
        end
    end

    // ======================================================================
    // Registers
    // ======================================================================
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_reg.enable     <= ctt_pkg::ENABLE_RST;
            st_reg.irq_enable <= ctt_pkg::IRQ_EN_RST;
            st_reg.clk_sel    <= ctt_pkg::CLK_SEL_RST;
            st_reg.zero_flag  <= ctt_pkg::FLAG_RST;
            st_reg.reload     <= ctt_pkg::RELOAD_RST;
            st_reg.calib      <= ctt_pkg::CALIB_RST;
            st_reg.rdata      <= '0;
            st_reg.rvalid     <= 1'b0;
            st_reg.irq        <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata  = st_reg.rdata;
    assign reg_rvalid = st_reg.rvalid;
    assign tick_irq   = st_reg.irq;

    // ======================================================================
    // Check helpers
    // ======================================================================
    // The control and write-data bits that the checks compare across a cycle,
    // and the mapped-read decode, are gathered here as plain signals.
    logic [2:0]                ctl_bits;
    logic [2:0]                wdata_ctl;
    logic [ctt_pkg::CNT_W-1:0] wdata_cnt;
    logic                      rd_mapped;

    assign ctl_bits  = {st_reg.clk_sel, st_reg.irq_enable, st_reg.enable};
    assign wdata_ctl = reg_wdata[ctt_pkg::CSR_CLK_SEL_BIT:ctt_pkg::CSR_ENABLE_BIT];
    assign wdata_cnt = reg_wdata[ctt_pkg::CNT_W-1:0];
    assign rd_mapped = rd_csr || rd_rvr || rd_cvr || rd_cal;

    // ======================================================================
    // Checks
    // ======================================================================
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_zero_event;
        cif.zero_evt;
    endsequence

    sequence s_flag_read_quiet;
        rd_csr && !cif.zero_evt;
    endsequence

    sequence s_half_rate_tick;
        cif.tick && !cif.full_rate ##1 !cif.full_rate;
    endsequence

    sequence s_live_tick;
        cif.run && cif.tick && !cif.clear;
    endsequence

    sequence s_masked_zero;
        cif.zero_evt && !st_reg.irq_enable;
    endsequence

    sequence s_half_rate_start;
        $rose(cif.run) && !cif.full_rate;
    endsequence

    sequence s_idle_count;
        !cif.run && !cif.clear;
    endsequence

    a_flag_sets_zero:   assert property (s_zero_event |=> st_reg.zero_flag)
        else $error("zero flag not set after counter reached zero");

    a_flag_read_clr:    assert property (s_flag_read_quiet |=> !st_reg.zero_flag)
        else $error("zero flag not cleared by control read");

    a_cvr_write_clr:    assert property (wr_cvr && !cif.zero_evt |=>
                                         cif.count == '0 && !st_reg.zero_flag)
        else $error("current-count write did not clear count and flag");

    a_irq_on_zero:      assert property (s_zero_event ##0 st_reg.irq_enable |=> tick_irq)
        else $error("tick interrupt missing at zero");

    a_irq_has_cause:    assert property (tick_irq |-> $past(cif.zero_evt) && $past(st_reg.irq_enable))
        else $error("tick interrupt without enabled zero event");

    a_stop_holds:       assert property (!st_reg.enable && !cif.clear |=> $stable(cif.count))
        else $error("counter moved while disabled");

    a_reload_at_zero:   assert property (s_live_tick ##0 cif.count == '0 |=>
                                         cif.count == $past(st_reg.reload))
        else $error("counter did not reload at zero");

    a_decrement_one:    assert property (s_live_tick ##0 cif.count != '0 |=>
                                         cif.count == $past(cif.count) - 24'h000001)
        else $error("counter did not step down by one");

    a_half_rate_gap:    assert property (s_half_rate_tick |-> !cif.tick)
        else $error("half-rate count clock ticked twice in a row");

    a_full_rate_tick:   assert property (cif.run && cif.full_rate |-> cif.tick)
        else $error("full-rate count clock missed a cycle");

    a_read_count_live:  assert property (rd_cvr |=> reg_rvalid &&
                                         reg_rdata == {8'h00, $past(cif.count)})
        else $error("current-count read returned wrong value");

    a_read_ctl_map:     assert property (rd_csr |=> reg_rvalid &&
                                         reg_rdata[2:0] == $past(ctl_bits))
        else $error("control read returned wrong fields");

    a_irq_masked:       assert property (s_masked_zero |=> !tick_irq)
        else $error("tick interrupt raised while masked");

    a_irq_one_cycle:    assert property (tick_irq |=> !tick_irq)
        else $error("tick interrupt longer than one cycle");

    a_zero_evt_count:   assert property (cif.zero_evt |-> cif.count == '0)
        else $error("zero event with a nonzero count");

    a_reload_no_event:  assert property (s_live_tick ##0 cif.count == '0 |=> !cif.zero_evt)
        else $error("reload from zero raised a zero event");

    a_stop_no_tick:     assert property (!cif.run |-> !cif.tick)
        else $error("count clock ticked while disabled");

    a_stop_no_event:    assert property (s_idle_count |=> !cif.zero_evt)
        else $error("zero event while disabled");

    a_half_rate_first:  assert property (s_half_rate_start |-> !cif.tick)
        else $error("half-rate count clock ticked on the enabling cycle");

    a_flag_sticky:      assert property (st_reg.zero_flag && !rd_csr && !wr_cvr |=> st_reg.zero_flag)
        else $error("zero flag dropped without a clear");

    a_flag_has_cause:   assert property (!st_reg.zero_flag && !cif.zero_evt |=> !st_reg.zero_flag)
        else $error("zero flag set without a zero event");

    a_csr_write_ctl:    assert property (wr_csr |=> ctl_bits == $past(wdata_ctl))
        else $error("control write did not land");

    a_rvr_write:        assert property (wr_rvr |=> st_reg.reload == $past(wdata_cnt))
        else $error("reload write did not land");

    a_read_rvr_map:     assert property (rd_rvr |=> reg_rvalid &&
                                         reg_rdata == {8'h00, $past(st_reg.reload)})
        else $error("reload read returned wrong value");

    a_read_cal_map:     assert property (rd_cal |=> reg_rvalid &&
                                         reg_rdata == {8'h00, $past(st_reg.calib)})
        else $error("calibration read returned wrong value");

    a_read_unmapped:    assert property (reg_rd && !rd_mapped |=> reg_rvalid && reg_rdata == '0)
        else $error("unmapped read returned data");

    a_rvalid_only_rd:   assert property (!reg_rd |=> !reg_rvalid)
        else $error("read valid without a read strobe");

    a_rdata_idle_zero:  assert property (!reg_rvalid |-> reg_rdata == '0)
        else $error("read data not zero outside a read");

    a_flag_read_bit:    assert property (rd_csr |=> reg_rdata[ctt_pkg::CSR_ZERO_FLG_BIT] == $past(st_reg.zero_flag))
        else $error("control read lost the zero flag");

    a_read_ctl_rsvd:    assert property (rd_csr |=> reg_rdata[31:17] == '0 && reg_rdata[15:3] == '0)
        else $error("control read showed reserved bits");
endmodule

// File: bench/test_core_tick_timer.sv
`timescale 1ns/1ps
// ==========================================================================
// Comparison helper
// ==========================================================================
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_count++; \
    $display("[FAIL] %0t ns: value %0h, expected %0h", $time, (got), (exp)); end end

module test_core_tick_timer;

    localparam int unsigned LIMIT = 3000;

    logic                         core_clk;
    logic                         rst;
    logic [ctt_pkg::ADDR_W-1:0]   reg_addr;
    logic                         reg_wr;
    logic                         reg_rd;
    logic [ctt_pkg::DATA_W-1:0]   reg_wdata;
    logic [ctt_pkg::CNT_W-1:0]    calibration_source_setting;
    logic [ctt_pkg::DATA_W-1:0]   reg_rdata;
    logic                         reg_rvalid;
    logic                         tick_irq;
    logic [ctt_pkg::DATA_W-1:0]   rd_q[$];
    int unsigned                  irq_q[$];
    logic [ctt_pkg::DATA_W-1:0]   exp_d;
    int unsigned                  exp_c;
    int unsigned                  cyc;
    int unsigned                  err_count;
    int unsigned                  tests_run;
    int unsigned                  t;
    int unsigned                  c;
    int unsigned                  r;
    int unsigned                  h;

    ctt_core_tick_timer u_dut (
        .core_clk                   (core_clk),
        .rst                        (rst),
        .reg_addr                   (reg_addr),
        .reg_wr                     (reg_wr),
        .reg_rd                     (reg_rd),
        .reg_wdata                  (reg_wdata),
        .calibration_source_setting (calibration_source_setting),
        .reg_rdata                  (reg_rdata),
        .reg_rvalid                 (reg_rvalid),
        .tick_irq                   (tick_irq)
    );

    // ======================================================================
    // Clock, cycle count and hang guard
    // ======================================================================
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    initial cyc = 0;
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
    end

    always @(posedge core_clk) begin
        if (cyc >= LIMIT) begin
            err_count++;
            $display("[FAIL] %0t ns: run did not finish in time", $time);
            conclude();
        end
    end

    // ======================================================================
    // Output watcher: sampled mid-cycle, where registered outputs are settled
    // ======================================================================
    always @(negedge core_clk) begin
        if (reg_rvalid === 1'b1) begin
            if (rd_q.size() == 0) begin
                err_count++;
                $display("[FAIL] %0t ns: read data nobody asked for", $time);
            end else begin
                exp_d = rd_q.pop_front();
                `CHK(reg_rdata, exp_d)
            end
        end
        if (tick_irq === 1'b1) begin
            // Cycle-exact: a late or early pulse is as wrong as a missing one.
            if (irq_q.size() == 0) begin
                err_count++;
                $display("[FAIL] %0t ns: tick interrupt not expected", $time);
            end else begin
                exp_c = irq_q.pop_front();
                `CHK(cyc, exp_c)
            end
        end
    end

    // ======================================================================
    // Bus tasks: one idle edge between requests keeps the strobes clean
    // ======================================================================
    task automatic wr(input logic [ctt_pkg::ADDR_W-1:0] a, input logic [ctt_pkg::DATA_W-1:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        t = cyc + 1;
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [ctt_pkg::ADDR_W-1:0] a, input logic [ctt_pkg::DATA_W-1:0] e);
        rd_q.push_back(e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic wait_irqs();
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (irq_q.size() != 0 && n < 200);
        if (n >= 200) begin
            err_count++;
            $display("[FAIL] %0t ns: tick interrupts missing", $time);
        end
    endtask

    task automatic conclude();
        $display("checks %0d, errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ======================================================================
    // Main sequence
    // ======================================================================
    initial begin
        err_count = 0;
        tests_run = 0;
        void'($urandom(4111));
        rst       = 1'b1;
        reg_addr  = 12'h000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 32'h00000000;
        calibration_source_setting = 24'($urandom);
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rd(ctt_pkg::OFF_CONTROL_STATUS, 32'h00000000);
        rd(ctt_pkg::OFF_RELOAD_VALUE, 32'h00000000);
        rd(ctt_pkg::OFF_CURRENT_COUNT, 32'h00000000);
        rd(ctt_pkg::OFF_CALIBRATION, {8'h00, calibration_source_setting});
        rd(12'h020, 32'h00000000);
        @(posedge core_clk);
        calibration_source_setting <= 24'($urandom);
        wr(ctt_pkg::OFF_CALIBRATION, 32'h00FFFFFF);
        rd(ctt_pkg::OFF_CALIBRATION, {8'h00, calibration_source_setting});

        // Full rate, three periods, then stopped between zero events.
        r = 10 + $urandom % 6;
        wr(ctt_pkg::OFF_RELOAD_VALUE, 32'(r));
        rd(ctt_pkg::OFF_RELOAD_VALUE, 32'(r));
        wr(ctt_pkg::OFF_CURRENT_COUNT, {8'h00, 24'($urandom)});
        wr(ctt_pkg::OFF_CONTROL_STATUS, 32'h00000007);
        // Reload at the first edge, r steps down, then one edge to the pulse.
        c = t + r + 2;
        irq_q.push_back(c);
        irq_q.push_back(c + r + 1);
        c = c + 2 * r + 2;
        irq_q.push_back(c);
        wait_irqs();
        rd(ctt_pkg::OFF_CONTROL_STATUS, 32'h00010007);
        rd(ctt_pkg::OFF_CONTROL_STATUS, 32'h00000007);
        wr(ctt_pkg::OFF_CONTROL_STATUS, 32'h00000000);
        // Seven full-rate steps follow the reload before the stop lands.
        rd(ctt_pkg::OFF_CURRENT_COUNT, 32'(r - 7));
        repeat (20) @(posedge core_clk);
        rd(ctt_pkg::OFF_CURRENT_COUNT, 32'(r - 7));

        // Half rate, two periods, then a clearing write to the count.
        h = 3 + $urandom % 4;
        wr(ctt_pkg::OFF_RELOAD_VALUE, 32'(h));
        wr(ctt_pkg::OFF_CURRENT_COUNT, 32'h00000000);
        wr(ctt_pkg::OFF_CONTROL_STATUS, 32'h00000003);
        c = t + 2 * h + 3;
        irq_q.push_back(c);
        irq_q.push_back(c + 2 * h + 2);
        wait_irqs();
        wr(ctt_pkg::OFF_CONTROL_STATUS, 32'h00000000);
        wr(ctt_pkg::OFF_CURRENT_COUNT, {8'h00, 24'($urandom)});
        rd(ctt_pkg::OFF_CONTROL_STATUS, 32'h00000000);
        rd(ctt_pkg::OFF_CURRENT_COUNT, 32'h00000000);

        // Counting with the interrupt masked: flag only, no pulse. The reload
        // is copied from the calibration value, taken as matching this clock.
        calibration_source_setting <= 24'h000003;
        rd(ctt_pkg::OFF_CALIBRATION, 32'h00000003);
        wr(ctt_pkg::OFF_RELOAD_VALUE, {8'h00, calibration_source_setting});
        wr(ctt_pkg::OFF_CONTROL_STATUS, 32'h00000005);
        repeat (30) @(posedge core_clk);
        wr(ctt_pkg::OFF_CONTROL_STATUS, 32'h00000004);
        rd(ctt_pkg::OFF_CONTROL_STATUS, 32'h00010004);
        repeat (4) @(posedge core_clk);
        `CHK(rd_q.size() + irq_q.size(), 0)
        conclude();
    end

endmodule
